// *** dsl_pkg.sv ***
// constants for the diagnostic, standby and loop control register bank
// Overview of operation
// - diag and loop registers are read/write; writes act at chip-select rise
// - diag bit 15 enables bridge 1 sink current, bit 14 its source
// - diag bits 12..1 are sink/source pairs for outputs 6..1, sink upper
// - in run state, a set diagnostic enable with its pair partner clear imposes that current on its output or bridge
// - sink and source current never on the same output together
// - diag bit 13 is the second standby arming bit
// - one arming bit alone, or reverse order, never enters standby
// - standby starts at chip-select rise of the frame setting the second bit
// - standby ignores the link until the chip-select rise that ends the frame whose chip-select fall wakes it
// - loop register bits 6..4 select integral gain, 15..7 reserved
// - loop register bits 3..1 select proportional gain, bit 0 parity
// - proportional gain is 2 shifted left by the code, 2 to 256
// - integral gain is 1/128 doubled per code step, up to 1
// - gain selects return to defaults on power-on and software reset
// - spare register at 09H reads zero data with parity in bit 0
// - address 07H selects diag control, 08H loop control
// - fault indications stay latched until a clear opcode addressed to 10H arrives
// - first arming bit lives at bit 13 of bridge monitor register 06H
`default_nettype none
package dsl_pkg;
    localparam int          FRAME_BITS     = 24;
    localparam int          OUTPUTS        = 6;
    localparam int          FAULT_BITS     = 12;
    localparam logic [1:0]  OP_WRITE       = 2'h0;
    localparam logic [1:0]  OP_READ        = 2'h1;
    localparam logic [1:0]  OP_RDCLR       = 2'h2;
    localparam logic [1:0]  OP_SWRST       = 2'h3;
    localparam logic [5:0]  ADDR_BRIDGE    = 6'h06;
    localparam logic [5:0]  ADDR_DIAG      = 6'h07;
    localparam logic [5:0]  ADDR_LOOP      = 6'h08;
    localparam logic [5:0]  ADDR_SPARE     = 6'h09;
    localparam logic [5:0]  ADDR_FAULT     = 6'h10;
    localparam int          EXT_SINK_BIT   = 15;
    localparam int          EXT_SRC_BIT    = 14;
    localparam int          ARM_BIT        = 13;
    localparam int          PROP_LSB       = 1;
    localparam int          INTEG_LSB      = 4;
    localparam logic [15:0] RST_BRIDGE     = 16'h0176;
    localparam logic [15:0] RST_DIAG       = 16'h0000;
    localparam logic [2:0]  RST_PROP_SEL   = 3'h3;
    localparam logic [2:0]  RST_INTEG_SEL  = 3'h3;
    localparam logic [8:0]  PROP_GAIN_BASE = 9'h002;
    localparam logic [2:0]  INTEG_SHIFT_MAX = 3'h7;
    typedef enum logic [1:0] {
        ST_RUN     = 2'b00,
        ST_STANDBY = 2'b01,
        ST_WAKE    = 2'b10
    } dsl_power_t;
endpackage : dsl_pkg
`default_nettype wire

// *** dsl_link_if.sv ***
// interface between the serial shifter and the register core
`default_nettype none
interface dsl_link_if;
    logic [23:0] frameWord;
    logic        frameToggle;
    logic [15:0] replyWord;
    modport link (output frameWord, output frameToggle, input replyWord);
    modport core (input frameWord, input frameToggle, output replyWord);
endinterface : dsl_link_if
`default_nettype wire

// *** dsl_spi_shifter.sv ***
// serial frame shifter running on the link clock
`default_nettype none
module dsl_spi_shifter
    import dsl_pkg::*;
(
    input  wire logic serialClk,
    input  wire logic reset_n,
    input  wire logic chipSelectLow,
    input  wire logic serialDataIn,
    output logic      serialDataOut,
    output logic      serialOutEnable_n,
    dsl_link_if.link  link
);
    logic        frameRst_n;
    logic [4:0]  bitCount;
    logic [22:0] rxShift;
    logic [23:0] txWord;
    logic [4:0]  txIndex;

    // ----------------------------------------
    // receive side
    // ----------------------------------------
    assign frameRst_n = reset_n & ~chipSelectLow;
    assign txWord     = {8'h00, link.replyWord};
    assign txIndex    = 5'(FRAME_BITS - 1) - bitCount;

    always_ff @(posedge serialClk or negedge frameRst_n)
    begin
        if (!frameRst_n)
        begin
            bitCount <= 5'h00;
            rxShift  <= 23'h000000;
        end
        else
        begin
            if (bitCount != 5'(FRAME_BITS))
                bitCount <= bitCount + 5'h01;
            rxShift <= {rxShift[21:0], serialDataIn};
        end
    end

    // frame word held until the next full frame
    always_ff @(posedge serialClk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            link.frameWord   <= 24'h000000;
            link.frameToggle <= 1'b0;
        end
        else if (!chipSelectLow && bitCount == 5'(FRAME_BITS - 1))
        begin
            link.frameWord   <= {rxShift, serialDataIn};
            link.frameToggle <= ~link.frameToggle;
        end
    end

    // ----------------------------------------
    // transmit side
    // ----------------------------------------
    always_ff @(negedge serialClk or negedge frameRst_n)
    begin
        if (!frameRst_n)
        begin
            serialDataOut     <= 1'b0;
            serialOutEnable_n <= 1'b1;
        end
        else
        begin
            serialOutEnable_n <= 1'b0;
            serialDataOut     <= (bitCount < 5'(FRAME_BITS)) ? txWord[txIndex] : 1'b0;
        end
    end
endmodule : dsl_spi_shifter
`default_nettype wire

// *** dsl_regs.sv ***
// register core: diagnostic currents, standby arming and loop gains
`default_nettype none
module dsl_regs
    import dsl_pkg::*;
(
    input  wire logic                  ref_clk,
    input  wire logic                  reset_n,
    input  wire logic                  serialClk,
    input  wire logic                  chipSelectLow,
    input  wire logic                  serialDataIn,
    input  wire logic [FAULT_BITS-1:0] faultEvents,
    output logic                       serialDataOut,
    output logic                       serialOutEnable_n,
    output logic [OUTPUTS-1:0]         outputDiagSinkEn,
    output logic [OUTPUTS-1:0]         outputDiagSourceEn,
    output logic                       extBridge1DiagSinkEn,
    output logic                       extBridge1DiagSourceEn,
    output logic                       standbyActive,
    output logic [2:0]                 propGainSelect,
    output logic [2:0]                 integGainSelect,
    output logic [8:0]                 propGain,
    output logic [2:0]                 integGainShift
);
    // ----------------------------------------
    // decode helpers
    // ----------------------------------------
    function automatic logic [15:0] withParity(input logic [15:0] v);
        withParity = {v[15:1], ~^v[15:1]};
    endfunction : withParity

    function automatic logic [4:0] decodeAddr(input logic [5:0] adr);
        decodeAddr = {adr == ADDR_FAULT, adr == ADDR_SPARE, adr == ADDR_LOOP, adr == ADDR_DIAG, adr == ADDR_BRIDGE};
    endfunction : decodeAddr

    // ----------------------------------------
    // serial link front end
    // ----------------------------------------
    dsl_link_if linkBus ();
    dsl_spi_shifter u_shifter (
        .serialClk         (serialClk),
        .reset_n           (reset_n),
        .chipSelectLow     (chipSelectLow),
        .serialDataIn      (serialDataIn),
        .serialDataOut     (serialDataOut),
        .serialOutEnable_n (serialOutEnable_n),
        .link              (linkBus.link)
    );

    // ----------------------------------------
    // synchronisers
    // ----------------------------------------
    logic [2:0] csSync;
    logic [2:0] tglSync;
    logic       csLevel;
    logic       tglLevel;
    logic       csRise;
    logic       csFall;
    logic       frameArrived;
    logic       pendingFrame;

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            csSync  <= 3'h7;
            tglSync <= 3'h0;
        end
        else
        begin
            csSync  <= {csSync[1:0], chipSelectLow};
            tglSync <= {tglSync[1:0], linkBus.frameToggle};
        end
    end

    assign csRise       = ~csLevel & csSync[1] & csSync[2];
    assign csFall       = csLevel & ~csSync[1] & ~csSync[2];
    assign frameArrived = (tglSync[1] == tglSync[2]) && (tglSync[2] != tglLevel);

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            csLevel  <= 1'b1;
            tglLevel <= 1'b0;
        end
        else
        begin
            if (csRise)
                csLevel <= 1'b1;
            else if (csFall)
                csLevel <= 1'b0;
            if (tglSync[1] == tglSync[2])
                tglLevel <= tglSync[2];
        end
    end

    // a complete frame waits for its chip-select rise
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            pendingFrame <= 1'b0;
        else if (frameArrived)
            pendingFrame <= 1'b1;
        else if (csRise || csFall)
            pendingFrame <= 1'b0;
    end

    // ----------------------------------------
    // frame decode
    // ----------------------------------------
    logic [1:0]  frameOp;
    logic [5:0]  frameAddr;
    logic [15:0] frameData;
    logic [4:0]  sel;
    logic        frameDone;
    logic        commit;
    logic        writeCmd;
    logic        swReset;
    logic        faultClear;
    logic        enterStandby;
    dsl_power_t  powerState;
    dsl_power_t  next_powerState;
    logic [15:0] bridgeMon;
    logic [15:0] diagCtrl;
    logic [5:0]  loopSel;
    logic [FAULT_BITS-1:0] faultLatch;

    assign frameOp    = linkBus.frameWord[23:22];
    assign frameAddr  = linkBus.frameWord[21:16];
    assign frameData  = linkBus.frameWord[15:0];
    assign sel        = decodeAddr(frameAddr);
    assign frameDone  = csRise & (pendingFrame | frameArrived);
    assign commit     = frameDone & (powerState == ST_RUN);
    assign writeCmd   = commit && frameOp == OP_WRITE;
    assign swReset    = commit && frameOp == OP_SWRST;
    assign faultClear = commit && frameOp == OP_RDCLR && sel[4];

    // ----------------------------------------
    // power state
    // ----------------------------------------
    // second bit rising while first already held
    assign enterStandby = writeCmd && sel[1] && frameData[ARM_BIT]
                          && !diagCtrl[ARM_BIT] && bridgeMon[ARM_BIT];

    always_comb
    begin
        next_powerState = powerState;
        unique case (powerState)
            ST_RUN:
                if (enterStandby)
                    next_powerState = ST_STANDBY;
            ST_STANDBY:
                if (csFall)
                    next_powerState = ST_WAKE;
            ST_WAKE:
                if (csRise)
                    next_powerState = ST_RUN;
            default:
                next_powerState = ST_RUN;
        endcase
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            powerState <= ST_RUN;
        else
            powerState <= next_powerState;
    end

    // ----------------------------------------
    // control registers
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            bridgeMon <= RST_BRIDGE;
        else if (swReset)
            bridgeMon <= RST_BRIDGE;
        else if (enterStandby)
            bridgeMon[ARM_BIT] <= 1'b0;
        else if (writeCmd && sel[0])
            bridgeMon <= {frameData[15:1], 1'b0};
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            diagCtrl <= RST_DIAG;
        else if (swReset)
            diagCtrl <= RST_DIAG;
        else if (writeCmd && sel[1])
        begin
            diagCtrl          <= {frameData[15:1], 1'b0};
            diagCtrl[ARM_BIT] <= frameData[ARM_BIT] & ~enterStandby;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            loopSel <= {RST_INTEG_SEL, RST_PROP_SEL};
        else if (swReset)
            loopSel <= {RST_INTEG_SEL, RST_PROP_SEL};
        else if (writeCmd && sel[2])
            loopSel <= {frameData[INTEG_LSB+:3], frameData[PROP_LSB+:3]};
    end

    // new events win over a clear in the same cycle
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            faultLatch <= '0;
        else
            faultLatch <= (faultClear ? '0 : faultLatch) | faultEvents;
    end

    // ----------------------------------------
    // readback, out of frame
    // ----------------------------------------
    logic [15:0] next_reply;

    always_comb
    begin
        next_reply = 16'h0000;
        if (sel[0])
            next_reply = withParity(bridgeMon);
        else if (sel[1])
            next_reply = withParity(diagCtrl);
        else if (sel[2])
            next_reply = withParity({9'h000, loopSel, 1'b0});
        else if (sel[3])
            next_reply = withParity(16'h0000);
        else if (sel[4])
            next_reply = withParity({3'h0, faultLatch, 1'b0});
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            linkBus.replyWord <= 16'h0000;
        else if (commit)
            linkBus.replyWord <= next_reply;
    end

    // ----------------------------------------
    // diagnostic current drives
    // ----------------------------------------
    logic [OUTPUTS-1:0] next_sink;
    logic [OUTPUTS-1:0] next_source;
    logic               run;

    assign run = (powerState == ST_RUN);

    for (genvar i = 0; i < OUTPUTS; i++)
    begin : g_pair
        assign next_sink[i]   = run & diagCtrl[2*i+2] & ~diagCtrl[2*i+1];
        assign next_source[i] = run & diagCtrl[2*i+1] & ~diagCtrl[2*i+2];
        a_no_dual_drive: assert property (
            @(posedge ref_clk) disable iff (!reset_n)
            !(outputDiagSinkEn[i] && outputDiagSourceEn[i]))
            else $error("sink and source driven together");
        a_sink_follows: assert property (
            @(posedge ref_clk) disable iff (!reset_n)
            (run && diagCtrl[2*i+2] && !diagCtrl[2*i+1]) |=> outputDiagSinkEn[i])
            else $error("enabled sink current not driven");
        a_pair_blocked: assert property (
            @(posedge ref_clk) disable iff (!reset_n)
            (diagCtrl[2*i+2] && diagCtrl[2*i+1])
            |=> !outputDiagSinkEn[i] && !outputDiagSourceEn[i])
            else $error("conflicting pair still drives");
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            outputDiagSinkEn       <= '0;
            outputDiagSourceEn     <= '0;
            extBridge1DiagSinkEn   <= 1'b0;
            extBridge1DiagSourceEn <= 1'b0;
        end
        else
        begin
            outputDiagSinkEn       <= next_sink;
            outputDiagSourceEn     <= next_source;
            extBridge1DiagSinkEn   <= run & diagCtrl[EXT_SINK_BIT] & ~diagCtrl[EXT_SRC_BIT];
            extBridge1DiagSourceEn <= run & diagCtrl[EXT_SRC_BIT] & ~diagCtrl[EXT_SINK_BIT];
        end
    end

    // ----------------------------------------
    // status and gain outputs
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            standbyActive   <= 1'b0;
            propGainSelect  <= RST_PROP_SEL;
            integGainSelect <= RST_INTEG_SEL;
            propGain        <= PROP_GAIN_BASE << RST_PROP_SEL;
            integGainShift  <= INTEG_SHIFT_MAX - RST_INTEG_SEL;
        end
        else
        begin
            standbyActive   <= (next_powerState == ST_STANDBY);
            propGainSelect  <= loopSel[2:0];
            integGainSelect <= loopSel[5:3];
            propGain        <= PROP_GAIN_BASE << loopSel[2:0];
            integGainShift  <= INTEG_SHIFT_MAX - loopSel[5:3];
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_ext_sink: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        (run && diagCtrl[EXT_SINK_BIT] && !diagCtrl[EXT_SRC_BIT]) |=> extBridge1DiagSinkEn)
        else $error("bridge sink current not driven");
    a_standby_entry: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        enterStandby |=> standbyActive && powerState == ST_STANDBY)
        else $error("standby not entered");
    a_single_arm: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        (writeCmd && sel[1] && !bridgeMon[ARM_BIT]) |=> !standbyActive)
        else $error("standby without first arming bit");
    a_standby_deaf: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        (powerState != ST_RUN) |=> $stable(diagCtrl) && $stable(loopSel))
        else $error("register changed during standby");
    a_wake_fall: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        (powerState == ST_STANDBY && csFall) |=> powerState == ST_WAKE ##[1:400] powerState != ST_STANDBY)
        else $error("no wake on chip-select fall");
    a_loop_write: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        (writeCmd && sel[2]) |=> loopSel == frameData[6:1] ##1 propGainSelect == frameData[3:1])
        else $error("loop write not applied");
    a_prop_decode: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        propGain == (PROP_GAIN_BASE << propGainSelect))
        else $error("proportional gain decode wrong");
    a_integ_decode: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        (4'(integGainShift) + 4'(integGainSelect)) == 4'h7)
        else $error("integral gain decode wrong");
    a_gain_swreset: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        swReset |=> ##1 propGainSelect == RST_PROP_SEL && integGainSelect == RST_INTEG_SEL)
        else $error("gains not restored by software reset");
    a_fault_latched: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        !faultClear |=> (faultLatch & $past(faultLatch)) == $past(faultLatch))
        else $error("fault dropped without clear");
    a_spare_zero: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        (commit && sel[3]) |=> linkBus.replyWord == 16'h0001)
        else $error("spare register data not zero");
endmodule : dsl_regs
`default_nettype wire

// *** dsl_spi_host.sv ***
// serial host model issuing 24-bit command frames
`default_nettype none
module dsl_spi_host
(
    output logic      serialClk,
    output logic      chipSelectLow,
    output logic      serialDataIn,
    input  wire logic serialDataOut,
    input  wire logic serialOutEnable_n
);
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------------------------------
    // idle levels
    // ----------------------------------------
    initial
    begin
        serialClk     = 1'b0;
        chipSelectLow = 1'b1;
        serialDataIn  = 1'b0;
    end
    // ----------------------------------------
    // frame transfer, clock only inside frames
    // ----------------------------------------
    task automatic xfer(input logic [23:0] tx, output logic [15:0] rx);
        chipSelectLow = 1'b0;
        #20;
        for (int i = 23; i >= 0; i--)
        begin
            serialDataIn = tx[i];
            #7.5 serialClk = 1'b1;
            if (i < 16)
                rx[i] = serialOutEnable_n ? 1'bx : serialDataOut;
            #7.5 serialClk = 1'b0;
        end
        #15 chipSelectLow = 1'b1;
        serialDataIn = ~serialDataIn;
    endtask : xfer
endmodule : dsl_spi_host
`default_nettype wire

// *** dsl_regs_bench.sv ***
// self-checking bench of the diagnostic, standby and loop register core
`default_nettype none
module dsl_regs_bench
    import dsl_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic                  ref_clk     = 1'b0;
    logic                  reset_n     = 1'b0;
    logic [FAULT_BITS-1:0] faultEvents = '0;
    wire logic             serialClk, chipSelectLow, serialDataIn, serialDataOut, serialOutEnable_n;
    wire logic [OUTPUTS-1:0] sinkEn, srcEn;
    wire logic             extSink, extSrc, standbyActive;
    wire logic [2:0]       propSel, integSel, integShift;
    wire logic [8:0]       propGain;
    int                    errors       = 0;
    int                    total_checks = 0;
    int                    seed         = 70;
    logic [15:0]           rx, d, v;

    always #25 ref_clk = ~ref_clk;

    dsl_regs i_dut (.ref_clk(ref_clk), .reset_n(reset_n), .serialClk(serialClk), .chipSelectLow(chipSelectLow),
        .serialDataIn(serialDataIn), .faultEvents(faultEvents), .serialDataOut(serialDataOut),
        .serialOutEnable_n(serialOutEnable_n), .outputDiagSinkEn(sinkEn), .outputDiagSourceEn(srcEn),
        .extBridge1DiagSinkEn(extSink), .extBridge1DiagSourceEn(extSrc), .standbyActive(standbyActive),
        .propGainSelect(propSel), .integGainSelect(integSel), .propGain(propGain), .integGainShift(integShift));
    dsl_spi_host i_host (.serialClk(serialClk), .chipSelectLow(chipSelectLow), .serialDataIn(serialDataIn),
        .serialDataOut(serialDataOut), .serialOutEnable_n(serialOutEnable_n));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        total_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check
    function automatic logic [15:0] withParity(input logic [15:0] x);
        return {x[15:1], ~^x[15:1]};
    endfunction : withParity
    task automatic frame(input logic [1:0] op, input logic [5:0] adr, input logic [15:0] dat);
        i_host.xfer({op, adr, dat}, rx);
        repeat (10) @(posedge ref_clk);
        #1;
    endtask : frame
    task automatic checkDiag(input logic [15:0] x);
        for (int k = 0; k < OUTPUTS; k++)
        begin
            check({15'h0, sinkEn[k]}, {15'h0, x[2*k+2] & ~x[2*k+1]}, "sink enable");
            check({15'h0, srcEn[k]}, {15'h0, x[2*k+1] & ~x[2*k+2]}, "source enable");
        end
        check({14'h0, extSink, extSrc}, {14'h0, x[15] & ~x[14], x[14] & ~x[15]}, "bridge enables");
    endtask : checkDiag
    task automatic checkLoop(input logic [2:0] p, input logic [2:0] i);
        check({13'h0, propSel}, {13'h0, p}, "prop select");
        check({13'h0, integSel}, {13'h0, i}, "integ select");
        check({7'h0, propGain}, 16'h0002 << p, "prop gain");
        check({13'h0, integShift}, {13'h0, 3'h7 - i}, "integ shift");
    endtask : checkLoop
    task automatic conclude();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : conclude
    // ----------------------------------------
    // watchdog
    // ----------------------------------------
    initial
    begin
        #2000000;
        errors++;
        $display("wrong value at %0t: watchdog expired", $time);
        conclude();
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        repeat (2) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        #1;
        checkDiag(16'h0000);
        checkLoop(3'h3, 3'h3);
        frame(OP_READ, ADDR_DIAG, 16'h0000);
        frame(OP_READ, ADDR_LOOP, 16'h0000);
        check(rx, withParity(16'h0000), "diag reset");
        frame(OP_READ, ADDR_SPARE, 16'h0000);
        check(rx, withParity(16'h0036), "loop reset");
        for (int n = 0; n < 16; n++)
        begin
            d = (n == 0) ? 16'hDFFE : (n == 1) ? 16'hAAAA : 16'($random(seed));
            d[13] = 1'b0;
            frame(OP_WRITE, ADDR_DIAG, d);
            checkDiag(d);
            frame(OP_WRITE, ADDR_LOOP, d);
            checkLoop(d[3:1], d[6:4]);
            frame(OP_WRITE, ADDR_SPARE, 16'hFFFF);
            frame(OP_READ, ADDR_DIAG, 16'h0000);
            check(rx, 16'h0001, "spare readback");
            frame(OP_READ, ADDR_LOOP, 16'h0000);
            check(rx, withParity(d), "diag readback");
            frame(OP_READ, ADDR_SPARE, 16'h0000);
            check(rx, withParity(d & 16'h007E), "loop readback");
        end
        frame(OP_SWRST, ADDR_LOOP, 16'h0000);
        checkLoop(3'h3, 3'h3);
        frame(OP_WRITE, ADDR_DIAG, 16'h2000);
        check({15'h0, standbyActive}, 16'h0000, "second bit alone");
        frame(OP_WRITE, ADDR_BRIDGE, RST_BRIDGE | 16'h2000);
        check({15'h0, standbyActive}, 16'h0000, "reverse order");
        frame(OP_WRITE, ADDR_DIAG, 16'h0000);
        frame(OP_WRITE, ADDR_DIAG, 16'h2000);
        check({15'h0, standbyActive}, 16'h0001, "standby entry");
        frame(OP_WRITE, ADDR_DIAG, 16'h8000);
        check({15'h0, standbyActive}, 16'h0000, "wake");
        checkDiag(16'h0000);
        frame(OP_READ, ADDR_DIAG, 16'h0000);
        frame(OP_READ, ADDR_BRIDGE, 16'h0000);
        check(rx, 16'h0001, "wake frame ignored");
        v = (16'($random(seed)) & 16'h1FFE) | 16'h0002;
        @(posedge ref_clk);
        faultEvents <= v[12:1];
        @(posedge ref_clk);
        faultEvents <= '0;
        frame(OP_READ, ADDR_FAULT, 16'h0000);
        frame(OP_RDCLR, ADDR_FAULT, 16'h0000);
        check(rx, withParity(v), "fault latched");
        frame(OP_READ, ADDR_FAULT, 16'h0000);
        check(rx, withParity(v), "fault before clear");
        frame(OP_READ, ADDR_DIAG, 16'h0000);
        check(rx, 16'h0001, "fault cleared");
        conclude();
    end
endmodule : dsl_regs_bench
`default_nettype wire
